// file: include/sld_pkg.sv
// constants shared by both ends of the serial latched driver link
// ----------------------------------------------------------------
// Operation
// - clock rising edge captures serial data bit
// - later edges shift all eight stages onward
// - host sets data before capturing edge
// - strobe high follows register, low holds
// - latch bypass needs enable high while shifting
// - enable high blanks outputs, keeps state
// - enable low drives outputs from latches
// - strobe raised 300 ns after last edge
// - strobe pulse at least 100 ns wide
// - clock pulse at least 150 ns wide
// - data level held at least 150 ns
// - outputs follow strobe within 1.0 us
// ----------------------------------------------------------------
package sld_pkg;
  localparam int unsigned WIDTH         = 8;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned STB_DELAY_NS  = 300;
  localparam int unsigned STB_WIDTH_NS  = 100;
  localparam int unsigned SCK_WIDTH_NS  = 150;
  localparam int unsigned DATA_HOLD_NS  = 150;
  localparam real         OUT_DELAY_US  = 1.0;
  // least times round up to whole cycles
  localparam int unsigned STB_DELAY_CYC = (STB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STB_WIDTH_CYC = (STB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCK_HALF_CYC  = (SCK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [WIDTH-1:0] OUT_OFF  = 8'h00;
  localparam logic [WIDTH-1:0] ZERO     = 8'h00;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_LOW   = 3'b001,
    ST_HIGH  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_STB   = 3'b100
  } sld_host_st_t;
endpackage : sld_pkg

// file: include/sld_if.sv
// link between the host end and the latched driver end
`timescale 1ns/10ps
`default_nettype none
interface sld_if;
  logic                     sclk;
  logic                     sdata;
  logic                     strobe;
  logic                     enable;
  logic                     sdout;
  logic [sld_pkg::WIDTH-1:0] outs;

  modport host
  (
    output sclk,
    output sdata,
    output strobe,
    output enable,
    input  sdout,
    input  outs
  );
  modport dev
  (
    input  sclk,
    input  sdata,
    input  strobe,
    input  enable,
    output sdout,
    output outs
  );
endinterface : sld_if
`default_nettype wire

// file: hw/sld_dev.sv
// latched driver end: shift register, strobe latch and blanked outputs
`timescale 1ns/10ps
`default_nettype none
module sld_dev
#(
  parameter int unsigned WIDTH = sld_pkg::WIDTH
)
(
  sld_if.dev                    link,
  output logic [WIDTH-1:0]      o_latch,
  output logic [WIDTH-1:0]      o_shift
);
  // ----------------------------------------------------------------
  // shift register on the link clock
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_q;
  wire  [WIDTH-1:0] shift_d = {shift_q[WIDTH-2:0], link.sdata};

  always_ff @(posedge link.sclk)
  begin
    shift_q <= shift_d;
  end

  // ----------------------------------------------------------------
  // transparent latch, blanking and cascade output
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] latch_q;

  always_latch
  begin
    if (link.strobe)
      latch_q = shift_q;
  end

  assign link.outs  = link.enable ? sld_pkg::OUT_OFF : latch_q;
  assign link.sdout = shift_q[WIDTH-1];
  assign o_latch    = latch_q;
  assign o_shift    = shift_q;
endmodule : sld_dev
`default_nettype wire

// file: hw/sld_host.sv
// host end: fifo of bytes, clock divider and serial shifting with strobe
`timescale 1ns/10ps
`default_nettype none
module sld_fifo
#(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
)
(
  input  wire logic          i_clock,
  input  wire logic          i_srst,
  input  wire logic          i_valid,
  output logic               o_ready,
  input  wire logic [W-1:0]  i_data,
  output logic               o_valid,
  input  wire logic          i_ready,
  output logic [W-1:0]       o_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = i_valid && o_ready;
  wire           pop  = o_valid && i_ready;

  assign o_ready = (cnt_q != (AW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem[rp_q];

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wp_q] <= i_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
      if (pop)
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sld_fifo

module sld_host
#(
  parameter int unsigned WIDTH = sld_pkg::WIDTH,
  parameter int unsigned DEPTH = sld_pkg::FIFO_DEPTH
)
(
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_blank,
  output logic                  o_busy,
  output logic                  o_sdout,
  sld_if.host                   link
);
  // ----------------------------------------------------------------
  // byte queue
  // ----------------------------------------------------------------
  logic             f_valid;
  logic             f_ready;
  logic [WIDTH-1:0] f_data;

  sld_fifo #(.W(WIDTH), .D(DEPTH)) u_fifo
  (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_valid (i_valid),
    .o_ready (o_ready),
    .i_data  (i_data),
    .o_valid (f_valid),
    .i_ready (f_ready),
    .o_data  (f_data)
  );

  // ----------------------------------------------------------------
  // shift sequencer
  // ----------------------------------------------------------------
  sld_pkg::sld_host_st_t st_q;
  logic [WIDTH-1:0] sh_q;
  logic [3:0]       bit_q;
  logic [3:0]       cnt_q;
  logic             sclk_q;
  logic             sdat_q;
  logic             stb_q;
  logic             blank_q;
  logic [1:0]       sd_sync_q;

  wire cnt_done = (cnt_q == 4'h0);
  assign f_ready = (st_q == sld_pkg::ST_IDLE);
  assign o_busy  = (st_q != sld_pkg::ST_IDLE);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_q   <= sld_pkg::ST_IDLE;
      sh_q   <= sld_pkg::ZERO;
      bit_q  <= 4'h0;
      cnt_q  <= 4'h0;
      sclk_q <= 1'b0;
      sdat_q <= 1'b0;
      stb_q  <= 1'b0;
    end
    else
    begin
      if (!cnt_done)
        cnt_q <= cnt_q - 4'h1;
      case (st_q)
        sld_pkg::ST_IDLE:
          if (f_valid)
          begin
            sh_q   <= {f_data[WIDTH-2:0], 1'b0};
            sdat_q <= f_data[WIDTH-1];
            bit_q  <= 4'(WIDTH);
            cnt_q  <= 4'(sld_pkg::SCK_HALF_CYC);
            st_q   <= sld_pkg::ST_LOW;
          end
        sld_pkg::ST_LOW:
          if (cnt_done)
          begin
            sclk_q <= 1'b1;
            cnt_q  <= 4'(sld_pkg::SCK_HALF_CYC);
            bit_q  <= bit_q - 4'h1;
            st_q   <= sld_pkg::ST_HIGH;
          end
        sld_pkg::ST_HIGH:
          if (cnt_done)
          begin
            sclk_q <= 1'b0;
            if (bit_q == 4'h0)
            begin
              cnt_q <= 4'(sld_pkg::STB_DELAY_CYC);
              st_q  <= sld_pkg::ST_WAIT;
            end
            else
            begin
              sdat_q <= sh_q[WIDTH-1];
              sh_q   <= {sh_q[WIDTH-2:0], 1'b0};
              cnt_q  <= 4'(sld_pkg::SCK_HALF_CYC);
              st_q   <= sld_pkg::ST_LOW;
            end
          end
        sld_pkg::ST_WAIT:
          if (cnt_done)
          begin
            stb_q <= 1'b1;
            cnt_q <= 4'(sld_pkg::STB_WIDTH_CYC);
            st_q  <= sld_pkg::ST_STB;
          end
        sld_pkg::ST_STB:
          if (cnt_done)
          begin
            stb_q <= 1'b0;
            st_q  <= sld_pkg::ST_IDLE;
          end
        default:
          st_q <= sld_pkg::ST_IDLE;
      endcase
    end
  end

  // blanking register; cascade input synchronised
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      blank_q   <= 1'b1;
      sd_sync_q <= 2'b00;
    end
    else
    begin
      blank_q   <= i_blank;
      sd_sync_q <= {sd_sync_q[0], link.sdout};
    end
  end

  assign link.sclk   = sclk_q;
  assign link.sdata  = sdat_q;
  assign link.strobe = stb_q;
  assign link.enable = blank_q;
  assign o_sdout     = sd_sync_q[1];
endmodule : sld_host
`default_nettype wire

// file: tb/sld_chk_sva.sv
// link checker for both ends of the serial latched driver
`timescale 1ns/10ps
`default_nettype none
module sld_chk
(
  input wire logic                      i_clock,
  input wire logic                      i_srst,
  input wire logic                      sclk,
  input wire logic                      sdata,
  input wire logic                      strobe,
  input wire logic                      enable,
  input wire logic                      sdout,
  input wire logic [sld_pkg::WIDTH-1:0] outs
);
  logic       sclk_q;
  logic       ok_q;
  logic [3:0] cnt_q;
  logic [7:0] hist_q;
  logic [4:0] since_q;
  wire        rise = sclk & ~sclk_q;
  wire        full = cnt_q[3];
  // hist_q mirrors the bits the driver end should have taken
  always_ff @(posedge i_clock)
  begin
    sclk_q <= i_srst ? 1'b0 : sclk;
    ok_q   <= i_srst ? 1'b0 : ok_q | (strobe & full);
    cnt_q  <= i_srst ? 4'h0 : cnt_q + {3'h0, rise & ~full};
    hist_q <= rise ? {hist_q[6:0], sdata} : hist_q;
    // cycles since the last link clock rise, saturating
    since_q <= (i_srst || rise) ? 5'h00 : since_q + {4'h0, ~&since_q};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  AST_BLANK_OFF: assert property (enable |-> outs == 8'h00)
    else $error("outs on while blanked");
  AST_SOUT_STILL: assert property (!rise && full |-> $stable(sdout))
    else $error("serial out moved");
  AST_SHIFT_CHAIN: assert property (rise && full |-> sdout == hist_q[6])
    else $error("serial out wrong");
  AST_STB_FOLLOW: assert property (strobe && !enable && full |-> outs == hist_q)
    else $error("outs not register");
  AST_LATCH_HOLD: assert property (ok_q && !strobe && !enable && !$past(strobe) && !$past(enable) |-> $stable(outs))
    else $error("latch changed");
  AST_OUT_DELAY: assert property ($rose(strobe) && !enable && full |-> ##[0:39] outs == hist_q)
    else $error("outs late");
  AST_STB_GAP: assert property ($rose(strobe) |-> since_q >= 5'(sld_pkg::STB_DELAY_CYC - 1))
    else $error("strobe too early");
  AST_STB_WIDTH: assert property ($rose(strobe) |-> strobe[*4])
    else $error("strobe short");
  AST_SCK_WIDTH: assert property ($rose(sclk) |-> sclk[*6])
    else $error("clock pulse short");
  AST_DATA_HOLD: assert property ($changed(sdata) |=> $stable(sdata)[*5])
    else $error("data held short");
  AST_DATA_SETUP: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data moved at edge");
  cover property ($rose(strobe) && !enable);
  cover property ($rose(strobe) && enable);
  cover property (rise && full);
endmodule : sld_chk
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: host end drives the driver end over the link
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       i_clock = 1'b0;
  logic       i_srst  = 1'b1;
  logic       valid   = 1'b0;
  logic       blank   = 1'b0;
  logic [7:0] data    = 8'h00;
  logic       ready;
  logic       busy;
  logic       sdout;
  logic [7:0] latch;
  logic [7:0] shift;
  int         bad_count = 0;
  int         samples_checked = 0;
  sld_if i_sld_if ();
  sld_host i_sld_host (.i_clock(i_clock), .i_srst(i_srst), .i_valid(valid), .o_ready(ready), .i_data(data),
    .i_blank(blank), .o_busy(busy), .o_sdout(sdout), .link(i_sld_if.host));
  sld_dev i_sld_dev (.link(i_sld_if.dev), .o_latch(latch), .o_shift(shift));
  sld_chk i_sld_chk (.i_clock(i_clock), .i_srst(i_srst), .sclk(i_sld_if.sclk), .sdata(i_sld_if.sdata),
    .strobe(i_sld_if.strobe), .enable(i_sld_if.enable), .sdout(i_sld_if.sdout), .outs(i_sld_if.outs));
  initial
  begin
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  // pushes cnt bytes on consecutive edges, first upward
  task automatic send(input logic [7:0] first, input int cnt);
    valid = 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      data = first + 8'(i);
      tick(1);
    end
    valid = 1'b0;
  endtask : send
  task automatic wait_done();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    while (busy !== 1'b0 && n < 300)
    begin
      tick(1);
      n++;
    end
    if (n >= 300)
      bad_count++;
    tick(3);
  endtask : wait_done
  task automatic results();
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial
  begin
    tick(12);
    i_srst = 1'b0;
    send(8'hA5, 1);
    wait_done();
    check("outs", i_sld_if.outs, 8'hA5);
    check("latch", latch, 8'hA5);
    check("shift", shift, 8'hA5);
    check("sdout", {7'h00, sdout}, 8'h01);
    blank = 1'b1;
    tick(3);
    check("blank", i_sld_if.outs, 8'h00);
    check("keep", latch, 8'hA5);
    send(8'h3C, 1);
    wait_done();
    check("blank", i_sld_if.outs, 8'h00);
    check("latch", latch, 8'h3C);
    blank = 1'b0;
    tick(3);
    check("outs", i_sld_if.outs, 8'h3C);
    send(8'h01, 9);
    check("ready", {7'h00, ready}, 8'h00);
    repeat (9) wait_done();
    check("outs", i_sld_if.outs, 8'h09);
    check("sdout", {7'h00, sdout}, 8'h00);
    results();
  end
  initial
  begin
    #100000;
    bad_count++;
    results();
  end
endmodule : testbench
`default_nettype wire
